// ### rsop_pkg.sv
// Constants, pattern map and carrier types for the registered sum-of-products element.
// Assumes a 32-bit classic Wishbone slave port with word-aligned byte addresses.
// What this block does
// - Thirty-two logic terms, thirteen control terms and twenty sums, all from programmable links.
// - Eight registered pins and four two-way combinational lines.
// - Every term may see dedicated inputs, two-way lines, register states and the complement output.
// - Complement output is the NOR of connected terms and may feed any term.
// - Each term takes each variable true or inverted; complement is taken in one form.
// - Any logic term may drive a two-way line, each with its own inversion.
// - Any logic term may drive any J or K; JK rules apply on the clock edge.
// - The fold-back control term switches registers to JK behaviour while running.
// - Registers change on the clock edge or by preset/reset; each may be input, output or bus register.
// - Four control terms give preset and reset that act without the clock edge.
// - At power-on every register state is low, so its pin reads high.
// - Output-enable pin high floats register pins; low drives them inverted from state outside diagnostic mode.
// - A load captures the inverse of the forced pin level on the clock edge.
// - Diagnostic mode loads registers from pins regardless of pattern and floats two-way lines.
// - Direction and load terms allow sixteen inputs down to twelve outputs.
// - Output-select terms enable the two-way lines for bus use.
// - Blank pattern: output enabled, preset/reset off, transitions off, D mode, lines are inputs.
package rsop_pkg;

    localparam int unsigned N_IN = 4;
    localparam int unsigned N_BIO = 4;
    localparam int unsigned N_REG = 8;
    localparam int unsigned N_LOGIC = 32;
    localparam int unsigned N_CTRL = 13;
    localparam int unsigned N_TERM = 45;
    localparam int unsigned N_VAR = 16;
    localparam int unsigned WORDS_PER_TERM = 2;
    localparam int unsigned MEM_WORDS = 112;

    // Word indices of the pattern image; byte address is four times the index
    localparam logic [6:0] IDX_LINK_BASE = 7'h00;
    localparam logic [6:0] IDX_CMASK = 7'h5a;
    localparam logic [6:0] IDX_JMASK = 7'h5b;
    localparam logic [6:0] IDX_KMASK = 7'h63;
    localparam logic [6:0] IDX_BMASK = 7'h6b;
    localparam logic [6:0] IDX_POL = 7'h6f;
    localparam logic [6:0] IDX_STATUS = 7'h70;

    localparam int unsigned ADR_IDX_LSB = 2;
    localparam int unsigned ADR_IDX_MSB = 8;

    localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [7:0] Q_RESET = 8'h00;
    localparam logic [7:0] F_RESET = 8'hff;

    // Link word of one product term: a set bit means that link is blown
    typedef struct packed {
        logic [15:0] comp_blown;
        logic [15:0] true_blown;
    } rsop_link_t;

    // Control terms, lowest field at term index 32
    typedef struct packed {
        logic [3:0] out_en;
        logic [3:0] load;
        logic [1:0] reset;
        logic [1:0] preset;
        logic fold_back_control;
    } rsop_ctl_t;

    typedef struct packed {
        logic [5:0] zero;
        logic diag;
        logic oe_n;
        logic [3:0] b_pin;
        logic [3:0] ded_in;
        logic [7:0] f_pin;
        logic [7:0] q;
    } rsop_status_t;

endpackage : rsop_pkg

// ### rsop_pattern_mem.sv
// Programming pattern store: word-writable with byte lanes, registered read port,
// and the whole image presented in parallel to the product-term array.
// Assumes the caller decodes the index range and gives one write strobe per access.
`timescale 1ns/10ps
`default_nettype none
module rsop_pattern_mem import rsop_pkg::*; (
    input wire logic ref_clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic wr_en, // One-cycle write strobe
    input wire logic [3:0] sel, // Byte lanes of the write
    input wire logic [6:0] idx, // Word index
    input wire logic [31:0] wdata, // Write data
    output logic [31:0] rdata, // Registered read data
    output logic [MEM_WORDS*32-1:0] image // Whole pattern, parallel
);

    logic [31:0] mem_reg [MEM_WORDS];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int w = 0; w < MEM_WORDS; w++) begin
                mem_reg[w] <= PATTERN_RESET;
            end
        end else if (wr_en && (idx < IDX_STATUS)) begin
            for (int b = 0; b < 4; b++) begin
                if (sel[b]) begin
                    mem_reg[idx][8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= READ_ZERO;
        end else if (idx < IDX_STATUS) begin
            rdata <= mem_reg[idx];
        end else begin
            rdata <= READ_ZERO;
        end
    end

    for (genvar w = 0; w < MEM_WORDS; w++) begin : g_image
        assign image[w*32 +: 32] = mem_reg[w];
    end

endmodule : rsop_pattern_mem
`default_nettype wire

// ### rsop_top.sv
// Registered sum-of-products element: AND array with complement term, OR array,
// eight JK/D registers on two-way pins, four combinational two-way lines,
// and a Wishbone slave holding the link pattern.
// Assumes pins are synchronous to ref_clk and dev_clk_en marks device clock edges.
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rsop_top import rsop_pkg::*; (
    input wire logic ref_clk, // System clock, 50 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [31:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic dev_clk_en, // Device clock rising edge, one cycle
    input wire logic oe_n, // Register pin output enable, active low
    input wire logic diag_en, // Diagnostic mode level
    input wire logic [3:0] ded_in, // Dedicated inputs
    input wire logic [7:0] f_in, // Register pin levels
    output logic [7:0] f_out, // Register pin drive value
    output logic [7:0] f_oe, // Register pin drive enable
    input wire logic [3:0] b_in, // Two-way line levels
    output logic [3:0] b_out, // Two-way line drive value
    output logic [3:0] b_oe // Two-way line drive enable
);

    logic [MEM_WORDS*32-1:0] image;
    logic [31:0] mem_rdata;
    logic wb_req;
    logic take;
    logic pend_reg;
    logic [6:0] idx;
    logic adr_high_zero;
    logic in_mem;
    logic is_status;
    rsop_status_t status;

    logic [7:0] q_reg;
    logic [7:0] q_next;
    logic [N_VAR-1:0] vars;
    logic [N_TERM-1:0] pre;
    logic [N_TERM-1:0] c_use;
    logic [N_TERM-1:0] term;
    logic [N_LOGIC-1:0] lterm;
    logic [31:0] cmask;
    logic comp_nor;
    rsop_ctl_t ctl;
    logic [7:0] j_sum;
    logic [7:0] k_sum;
    logic [7:0] k_eff;
    logic [3:0] b_sum;
    logic [3:0] pol;

    // Register bus: request taken once, answered two edges later
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign take = wb_req & ~pend_reg & ~wb_ack_o;
    assign idx = wb_adr_i[ADR_IDX_MSB:ADR_IDX_LSB];
    assign adr_high_zero = (wb_adr_i[31:ADR_IDX_MSB+1] == 23'h000000) && (wb_adr_i[1:0] == 2'h0);
    assign in_mem = adr_high_zero && (idx < IDX_STATUS);
    assign is_status = adr_high_zero && (idx == IDX_STATUS);

    rsop_pattern_mem u_mem (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_en(take & wb_we_i & in_mem),
        .sel(wb_sel_i),
        .idx(idx),
        .wdata(wb_dat_i),
        .rdata(mem_rdata),
        .image(image)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= 1'b0;
            wb_ack_o <= 1'b0;
        end else begin
            pend_reg <= take;
            wb_ack_o <= pend_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= READ_ZERO;
        end else if (pend_reg) begin
            if (wb_we_i) begin
                wb_dat_o <= READ_ZERO;
            end else if (in_mem) begin
                wb_dat_o <= mem_rdata;
            end else if (is_status) begin
                wb_dat_o <= status;
            end else begin
                wb_dat_o <= READ_ZERO;
            end
        end
    end

    always_comb begin
        status = '0;
        status.diag = diag_en;
        status.oe_n = oe_n;
        status.b_pin = b_in;
        status.ded_in = ded_in;
        status.f_pin = f_in;
        status.q = q_reg;
    end

    // Array variables: dedicated inputs, two-way line levels, register states
    assign vars = {q_reg, b_in, ded_in};

    // Product terms; intact true and complement links together inhibit a term
    for (genvar t = 0; t < N_TERM; t++) begin : g_term
        rsop_link_t lk;
        assign lk = image[(WORDS_PER_TERM*t)*32 +: 32];
        assign pre[t] = &((lk.true_blown | vars) & (lk.comp_blown | ~vars));
        assign c_use[t] = image[(WORDS_PER_TERM*t+1)*32];
        assign term[t] = pre[t] & (~c_use[t] | comp_nor);
    end

    // Complement term is built from the terms before its own feedback, so no loop forms
    assign cmask = image[IDX_CMASK*32 +: 32];
    assign comp_nor = ~|(pre[N_LOGIC-1:0] & cmask);
    assign lterm = term[N_LOGIC-1:0];
    assign ctl = rsop_ctl_t'(term[N_TERM-1:N_LOGIC]);
    assign pol = image[IDX_POL*32 +: 4];

    for (genvar n = 0; n < N_REG; n++) begin : g_reg
        assign j_sum[n] = |(lterm & image[(IDX_JMASK+n)*32 +: 32]);
        assign k_sum[n] = |(lterm & image[(IDX_KMASK+n)*32 +: 32]);
        // Blank fold-back term means D mode: K follows the inverse of J
        assign k_eff[n] = ctl.fold_back_control ? k_sum[n] : ~j_sum[n];
    end

    for (genvar m = 0; m < N_BIO; m++) begin : g_bio
        assign b_sum[m] = |(lterm & image[(IDX_BMASK+m)*32 +: 32]);
    end

    // Next register state; preset and reset act on every system edge outside diagnostic mode, not only device edges
    always_comb begin
        q_next = q_reg;
        for (int n = 0; n < N_REG; n++) begin
            if (diag_en) begin
                if (dev_clk_en) begin
                    q_next[n] = ~f_in[n];
                end
            end else if (ctl.preset[n/4]) begin
                q_next[n] = 1'b1;
            end else if (ctl.reset[n/4]) begin
                q_next[n] = 1'b0;
            end else if (dev_clk_en) begin
                if (ctl.load[n/2]) begin
                    // JK terms are expected off during a load and are not looked at
                    q_next[n] = ~f_in[n];
                end else begin
                    case ({j_sum[n], k_eff[n]})
                        2'b00: q_next[n] = q_reg[n];
                        2'b01: q_next[n] = 1'b0;
                        2'b10: q_next[n] = 1'b1;
                        2'b11: q_next[n] = ~q_reg[n];
                        default: q_next[n] = q_reg[n];
                    endcase
                end
            end
        end
    end

    // One clock for all registers; device edges arrive as an enable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= Q_RESET;
            f_out <= F_RESET;
        end else begin
            q_reg <= q_next;
            f_out <= ~q_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            f_oe <= 8'h00;
        end else begin
            f_oe <= {N_REG{~oe_n & ~diag_en}};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            b_out <= 4'h0;
            b_oe <= 4'h0;
        end else begin
            b_out <= b_sum ^ pol;
            b_oe <= ctl.out_en & {N_BIO{~diag_en}};
        end
    end

endmodule : rsop_top
`default_nettype wire

// ### rsop_top_asserts.sv
// Checker for the registered sum-of-products element.
// Assumes one clock and a classic Wishbone master.
`timescale 1ns/10ps
`default_nettype none
module rsop_top_asserts import rsop_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [31:0] wb_adr_i, // Address
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic dev_clk_en, // Device edge
    input wire logic oe_n, // Pin enable
    input wire logic diag_en, // Diag mode
    input wire logic [7:0] f_in, // Pin levels
    input wire logic [7:0] f_out, // Pin drive
    input wire logic [7:0] f_oe, // Pin enable out
    input wire logic [3:0] b_oe // Line enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence req_start;
        $rose(wb_cyc_i && wb_stb_i);
    endsequence
    sequence ack_second;
        !wb_ack_o ##1 wb_ack_o;
    endsequence
    ack_latency_a: assert property (req_start |=> ack_second)
        else $error("ack not on second edge");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    write_data_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("write ack carries data");
    unmapped_zero_a: assert property (wb_ack_o && wb_adr_i[31:9] != 0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    oe_follow_a: assert property (rstn |=> f_oe == {8{~$past(oe_n) & ~$past(diag_en)}})
        else $error("pin enable wrong");
    diag_float_a: assert property (diag_en |=> b_oe == 4'h0 && f_oe == 8'h00)
        else $error("drivers on in diag");
    diag_load_a: assert property (diag_en && dev_clk_en |=> f_out == $past(f_in))
        else $error("diag load wrong");
    diag_hold_a: assert property (diag_en && !dev_clk_en |=> $stable(f_out))
        else $error("register moved without edge");
endmodule : rsop_top_asserts
`default_nettype wire

// ### rsop_far_model.sv
// Board logic sharing register pins and two-way lines.
// Assumes the bench gives the level the board forces.
`timescale 1ns/10ps
`default_nettype none
module rsop_far_model (
    input wire logic [7:0] f_out, // Element drive
    input wire logic [7:0] f_oe, // Element enable
    input wire logic [7:0] f_force, // Board level
    output logic [7:0] f_in, // Resolved pins
    input wire logic [3:0] b_out, // Element drive
    input wire logic [3:0] b_oe, // Element enable
    input wire logic [3:0] b_force, // Board level
    output logic [3:0] b_in // Resolved lines
);
    // Board drives only where the element lets go
    assign f_in = (f_oe & f_out) | (~f_oe & f_force);
    assign b_in = (b_oe & b_out) | (~b_oe & b_force);
endmodule : rsop_far_model
`default_nettype wire

// ### rsop_top_tb.sv
// Testbench: programs the pattern over Wishbone and checks pin behaviour.
// Assumes rsop_far_model resolves the shared pins.
`timescale 1ns/10ps
`default_nettype none
module rsop_top_tb import rsop_pkg::*;;
    logic ref_clk, rstn, cyc, stb, we, dce, oe_n, diag, ack;
    logic [31:0] adr, wdat, dat_o, rd;
    logic [3:0] sel, ded, b_force, b_in, b_out, b_oe;
    logic [7:0] f_force, f_in, f_out, f_oe;
    int miscompares, compares;

    rsop_top i_rsop_top (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .dev_clk_en(dce), .oe_n(oe_n), .diag_en(diag), .ded_in(ded), .f_in(f_in), .f_out(f_out),
        .f_oe(f_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe));
    rsop_far_model i_rsop_far_model (.f_out(f_out), .f_oe(f_oe), .f_force(f_force), .f_in(f_in),
        .b_out(b_out), .b_oe(b_oe), .b_force(b_force), .b_in(b_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait for the acknowledge
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic pulse();
        dce <= 1'b1;
        tick(1);
        dce <= 1'b0;
        tick(2);
    endtask : pulse
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        tick(3000);
        miscompares++;
        end_sim();
    end
    initial begin
        {rstn, cyc, stb, we, dce, oe_n, diag} <= '0;
        adr <= '0;
        wdat <= '0;
        sel <= 4'hf;
        ded <= 4'h5;
        b_force <= 4'ha;
        f_force <= 8'h00;
        miscompares = 0;
        compares = 0;
        tick(4);
        check({8'h0, f_oe, 4'h0, b_oe, f_out}, 32'h0000_00ff);
        tick(4);
        rstn <= 1'b1;
        tick(2);
        check({16'h0, f_oe, 4'h0, b_oe}, 32'hff00);
        wb(1'b0, 32'h1c0, '0);
        check(rd, 32'h00a5_ff00);
        wb(1'b1, 32'h0, 32'hffff_ffff);
        wb(1'b0, 32'h0, '0);
        check(rd, 32'hffff_ffff);
        wb(1'b1, 32'h16c, 32'h1);
        pulse();
        check({24'h0, f_out}, 32'hfe);
        wb(1'b1, 32'h16c, 32'h0);
        pulse();
        check({24'h0, f_out}, 32'hff);
        wb(1'b1, 32'h148, 32'hffff_ffff);
        wb(1'b1, 32'h1ac, 32'h1);
        tick(2);
        check({24'h0, b_oe, b_out}, 32'h11);
        wb(1'b1, 32'h1bc, 32'h1);
        tick(2);
        check({28'h0, b_out}, 32'h0);
        wb(1'b1, 32'h108, 32'hffff_ffff);
        tick(2);
        check({24'h0, f_out}, 32'hf0);
        wb(1'b1, 32'h118, 32'hffff_ffff);
        tick(2);
        check({24'h0, f_out}, 32'hf0);
        wb(1'b1, 32'h108, 32'h0);
        tick(2);
        check({24'h0, f_out}, 32'hff);
        wb(1'b1, 32'h118, 32'h0);
        wb(1'b1, 32'h128, 32'hffff_ffff);
        oe_n <= 1'b1;
        f_force <= 8'h02;
        tick(2);
        check({24'h0, f_oe}, 32'h0);
        pulse();
        wb(1'b0, 32'h1c0, '0);
        check({24'h0, rd[7:0]}, 32'h01);
        oe_n <= 1'b0;
        tick(2);
        check({16'h0, f_out, f_oe}, 32'hfeff);
        wb(1'b1, 32'h128, 32'h0);
        diag <= 1'b1;
        f_force <= 8'h5a;
        tick(2);
        pulse();
        check({8'h0, f_out, f_oe, 4'h0, b_oe}, 32'h005a_0000);
        diag <= 1'b0;
        wb(1'b0, 32'h1c4, '0);
        check(rd, 32'h0);
        wb(1'b0, 32'h200, '0);
        check(rd, 32'h0);
        // Fold-back term set: register 7 toggles on J and K, the others hold
        wb(1'b1, 32'h100, 32'hffff_ffff);
        wb(1'b1, 32'h188, 32'h1);
        wb(1'b1, 32'h1a8, 32'h1);
        pulse();
        check({24'h0, f_out}, 32'hda);
        pulse();
        check({24'h0, f_out}, 32'h5a);
        // Term 1 gated by the complement output, seen on two-way line 0
        wb(1'b1, 32'h8, 32'hffff_ffff);
        wb(1'b1, 32'hc, 32'h1);
        wb(1'b1, 32'h1ac, 32'h2);
        tick(2);
        check({28'h0, b_out}, 32'h0);
        wb(1'b1, 32'h168, 32'h1);
        tick(2);
        check({28'h0, b_out}, 32'h1);
        // Term 2 needs dedicated input 1 high in true form
        wb(1'b1, 32'h10, 32'hffff_fffd);
        wb(1'b1, 32'h1ac, 32'h4);
        tick(2);
        check({28'h0, b_out}, 32'h1);
        ded <= 4'h7;
        tick(2);
        check({28'h0, b_out}, 32'h0);
        end_sim();
    end
endmodule : rsop_top_tb

bind rsop_top rsop_top_asserts i_rsop_top_asserts (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .dev_clk_en, .oe_n, .diag_en, .f_in, .f_out, .f_oe, .b_oe);
`default_nettype wire
